// ==== bus_handshake.sv ====
/*
  Avalon-MM wait-state generator: one wait cycle per access.
  Assumes the master holds read or write until waitrequest is low.
*/
`timescale 1ns/1ns
module bus_handshake (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus request
  input wire logic read,
  input wire logic write,
  // answer
  output logic waitrequest,
  output logic load,
  output logic take
);

  logic wait_reg;
  wire req = read | write;

  // load: read data is captured; take: the access completes
  assign load = req & wait_reg;
  assign take = req & ~wait_reg;
  assign waitrequest = wait_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~load;
    end
  end

endmodule

// ==== irq_status.sv ====
/*
  Sticky event status with write-one-to-clear, mask and level interrupt.
  Assumes set and clear pulses come from the same clock domain.
*/
`timescale 1ns/1ns
module irq_status #(
  parameter int N = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // events and software access
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  input wire logic mask_we,
  input wire logic [N-1:0] mask_in,
  // state
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);

  logic [N-1:0] status_next;
  logic [N-1:0] mask_next;

  // an event in the clearing cycle is kept: set wins
  assign status_next = set | (status & ~clr);
  assign mask_next = mask_we ? mask_in : mask;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
    end else begin
      status <= status_next;
      mask <= mask_next;
      irq <= |(status_next & mask_next);
    end
  end

endmodule

// ==== rx_dma_completion_state.sv ====
/*
  Receive DMA packet/buffer byte counts, first-descriptor state and
  completion pointer with readback/compare acknowledge of the queue
  interrupt, behind an Avalon-MM slave.
  Assumes the packet engine drives rx_stream from the mclk domain and
  accepts a descriptor write-back pulse without back-pressure.
*/
`timescale 1ns/1ns
module rx_dma_completion_state (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register bus
  input wire logic [rx_dma_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // receive stream from the packet engine
  input rx_dma_pkg::rx_stream_s rx_stream,
  // descriptor write-back and interrupt
  output rx_dma_pkg::desc_write_s desc_write,
  output logic irq
);
  import rx_dma_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // bus handshake and decode
  // ----------------------------------------------------------------
  logic bus_load;
  logic bus_take;

  bus_handshake u_bus (
    .clk(mclk),
    .rst_n(rst_n),
    .read(avs_read),
    .write(avs_write),
    .waitrequest(avs_waitrequest),
    .load(bus_load),
    .take(bus_take)
  );

  wire [ADDR_W-1:0] word_addr = {avs_address[ADDR_W-1:2], 2'b00};
  wire hit_counts = word_addr == OFS_BYTE_COUNTS;
  wire hit_comp = word_addr == OFS_COMP_PTR;
  wire hit_first = word_addr == OFS_FIRST_DESC;
  wire hit_status = word_addr == OFS_IRQ_STATUS;
  wire hit_mask = word_addr == OFS_IRQ_MASK;
  wire wr_take = bus_take & avs_write;
  wire rd_take = bus_take & avs_read;
  wire wr_counts = wr_take & hit_counts;
  wire wr_comp = wr_take & hit_comp;
  wire wr_first = wr_take & hit_first;
  wire wr_status = wr_take & hit_status;
  wire wr_mask = wr_take & hit_mask;
  wire [29:0] wr_ptr = avs_writedata[31:PTR_LSB];
  wire wr_mode = avs_writedata[MODE_BIT];

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  logic [15:0] packet_byte_total_reg;
  logic [15:0] packet_byte_total_next;
  logic [15:0] buffer_space_left_reg;
  logic [15:0] buffer_space_left_next;
  logic [29:0] first_descriptor_pointer_reg;
  logic [29:0] first_descriptor_pointer_next;
  logic in_packet_reg;
  logic in_packet_next;
  logic [29:0] completed_descriptor_pointer_reg;
  logic [29:0] completed_descriptor_pointer_next;
  logic completion_access_select_reg;
  logic completion_access_select_next;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic [NUM_EVENTS-1:0] irq_status_v;
  logic [NUM_EVENTS-1:0] irq_mask_v;

  // ----------------------------------------------------------------
  // packet and buffer byte counting
  // ----------------------------------------------------------------
  wire start_pkt = rx_stream.pkt_start;
  wire end_pkt = rx_stream.pkt_end & in_packet_reg & ~start_pkt;
  // a byte in the start cycle is the first byte of the new packet
  wire byte_in = rx_stream.byte_strobe & (in_packet_reg | start_pkt);
  wire [15:0] total_base = start_pkt ? COUNT_RESET
                                     : packet_byte_total_reg;
  wire [15:0] total_count = total_base + 16'(byte_in);
  wire [15:0] space_base = rx_stream.buf_load ? rx_stream.buf_len
                                              : buffer_space_left_reg;
  wire space_zero = space_base == 16'h0000;
  // an empty buffer stays at zero; the extra byte is flagged as overrun
  wire [15:0] space_count = (byte_in & ~space_zero)
                            ? space_base - 16'h0001 : space_base;
  wire ev_empty = byte_in & (space_base == 16'h0001);
  wire ev_overrun = byte_in & space_zero;
  // the engine wins over a software write in the same cycle
  wire hw_counts = start_pkt | rx_stream.buf_load | byte_in;
  wire [31:0] counts_word = {packet_byte_total_reg, buffer_space_left_reg};
  wire [31:0] counts_merged = merge_be(counts_word, avs_writedata,
                                       avs_byteenable);
  wire sw_counts = wr_counts & ~hw_counts;

  assign packet_byte_total_next = sw_counts
      ? counts_merged[31:TOTAL_LSB] : total_count;
  assign buffer_space_left_next = sw_counts
      ? counts_merged[TOTAL_LSB-1:0] : space_count;

  // ----------------------------------------------------------------
  // first descriptor of the current packet
  // ----------------------------------------------------------------
  wire [31:0] first_word = {first_descriptor_pointer_reg, 1'b0,
                            in_packet_reg};
  wire [31:0] first_merged = merge_be(first_word, avs_writedata,
                                      avs_byteenable);
  wire sw_first = wr_first & ~start_pkt & ~end_pkt;

  assign first_descriptor_pointer_next = start_pkt
      ? rx_stream.start_ptr
      : sw_first ? first_merged[31:PTR_LSB]
      : first_descriptor_pointer_reg;
  assign in_packet_next = start_pkt ? 1'b1
      : end_pkt ? 1'b0
      : sw_first ? first_merged[IN_PACKET_BIT]
      : in_packet_reg;

  // ----------------------------------------------------------------
  // completion pointer and acknowledge
  // ----------------------------------------------------------------
  // software loads the pointer only when it selects readback mode;
  // a compare-mode write never disturbs the stored value
  wire [31:0] comp_merged = merge_be({completed_descriptor_pointer_reg,
                                      2'b00}, avs_writedata,
                                     avs_byteenable);
  wire sw_comp_load = wr_comp & wr_mode & ~end_pkt;
  wire compare_match = wr_comp & ~wr_mode
      & (wr_ptr == completed_descriptor_pointer_reg);
  wire readback_hit = rd_take & hit_comp
      & completion_access_select_reg;

  assign completed_descriptor_pointer_next = end_pkt
      ? rx_stream.end_ptr
      : sw_comp_load ? comp_merged[31:PTR_LSB]
      : completed_descriptor_pointer_reg;
  assign completion_access_select_next = (wr_comp & avs_byteenable[0])
      ? wr_mode : completion_access_select_reg;

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  logic [NUM_EVENTS-1:0] ev_set;
  logic [NUM_EVENTS-1:0] ev_clr;
  logic [NUM_EVENTS-1:0] w1c_bits;
  wire [31:0] mask_merged = merge_be(32'(irq_mask_v), avs_writedata,
                                     avs_byteenable);
  wire [31:0] wr_lanes = be_mask(avs_byteenable);

  assign w1c_bits = wr_status
      ? avs_writedata[NUM_EVENTS-1:0] & wr_lanes[NUM_EVENTS-1:0]
      : '0;

  always_comb begin
    ev_set = '0;
    ev_set[EV_COMPLETE] = end_pkt | readback_hit;
    ev_set[EV_BUF_EMPTY] = ev_empty;
    ev_set[EV_OVERRUN] = ev_overrun;
    ev_clr = w1c_bits;
    ev_clr[EV_COMPLETE] = w1c_bits[EV_COMPLETE] | compare_match;
  end

  irq_status #(
    .N(NUM_EVENTS)
  ) u_irq (
    .clk(mclk),
    .rst_n(rst_n),
    .set(ev_set),
    .clr(ev_clr),
    .mask_we(wr_mask),
    .mask_in(mask_merged[NUM_EVENTS-1:0]),
    .status(irq_status_v),
    .mask(irq_mask_v),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // read data is a snapshot taken one cycle before the access ends
  wire [31:0] comp_word = {completed_descriptor_pointer_reg, 2'b00};
  wire [31:0] rd_mux = hit_counts ? counts_word
      : hit_comp ? comp_word
      : hit_first ? first_word
      : hit_status ? 32'(irq_status_v)
      : hit_mask ? 32'(irq_mask_v)
      : 32'h00000000;

  assign readdata_next = bus_load
      ? (avs_read ? rd_mux : 32'h00000000) : readdata_reg;
  assign avs_readdata = readdata_reg;

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      packet_byte_total_reg <= COUNT_RESET;
      buffer_space_left_reg <= COUNT_RESET;
      first_descriptor_pointer_reg <= PTR_RESET;
      in_packet_reg <= 1'b0;
      completed_descriptor_pointer_reg <= PTR_RESET;
      completion_access_select_reg <= 1'b0;
      readdata_reg <= 32'h00000000;
    end else begin
      packet_byte_total_reg <= packet_byte_total_next;
      buffer_space_left_reg <= buffer_space_left_next;
      first_descriptor_pointer_reg <= first_descriptor_pointer_next;
      in_packet_reg <= in_packet_next;
      completed_descriptor_pointer_reg <=
          completed_descriptor_pointer_next;
      completion_access_select_reg <= completion_access_select_next;
      readdata_reg <= readdata_next;
    end
  end

  // packet length goes to word 3 of the first descriptor at end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      desc_write <= '0;
    end else begin
      desc_write.valid <= end_pkt;
      if (end_pkt) begin
        desc_write.addr <= {first_descriptor_pointer_reg, 2'b00}
                           + DESC_WORD3_OFFSET;
        desc_write.count <= total_count;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_eop_total_written: assert property (
    end_pkt |=> desc_write.valid
      && desc_write.count == $past(total_count)
      && desc_write.addr == {$past(first_descriptor_pointer_reg), 2'b00}
         + DESC_WORD3_OFFSET)
    else $error("packet length not written back at end of packet");

  a_start_restarts_total: assert property (
    start_pkt |=> packet_byte_total_reg == 16'($past(byte_in)))
    else $error("packet byte total not restarted at packet start");

  a_space_counts_down: assert property (
    byte_in && !rx_stream.buf_load && buffer_space_left_reg != 16'h0000
      && !wr_counts
    |=> buffer_space_left_reg == $past(buffer_space_left_reg) - 16'h0001)
    else $error("free buffer bytes not decremented");

  a_pointer_recorded: assert property (
    end_pkt |=> completed_descriptor_pointer_reg == $past(rx_stream.end_ptr)
      && irq_status_v[EV_COMPLETE])
    else $error("completion pointer not recorded");

  a_compare_clears: assert property (
    compare_match && !end_pkt && !readback_hit
    |=> !irq_status_v[EV_COMPLETE]
      && completed_descriptor_pointer_reg
         == $past(completed_descriptor_pointer_reg))
    else $error("matching compare did not clear queue interrupt");

  a_readback_sets: assert property (
    rd_take && hit_comp && completion_access_select_reg
    |-> avs_readdata[31:2] == $past(completed_descriptor_pointer_reg)
        ##1 irq_status_v[EV_COMPLETE])
    else $error("readback did not return pointer and raise interrupt");

  a_low_bits_zero: assert property (
    rd_take && hit_comp |-> avs_readdata[1:0] == 2'b00)
    else $error("mode or reserved bit read back nonzero");

  a_first_desc_kept: assert property (
    start_pkt |=> in_packet_reg
      && first_descriptor_pointer_reg == $past(rx_stream.start_ptr))
    else $error("first descriptor state not taken at packet start");

  a_reset_values: assert property (
    $rose(rst_n) |-> packet_byte_total_reg == COUNT_RESET
      && buffer_space_left_reg == COUNT_RESET
      && completed_descriptor_pointer_reg == PTR_RESET)
    else $error("state not zero after reset");

  a_end_clears_flag: assert property (
    end_pkt |=> !in_packet_reg)
    else $error("in-packet flag not cleared at end of packet");

  a_wait_released: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held more than one cycle");

endmodule

// ==== rx_dma_pkg.sv ====
/*
  Constants, carriers and helpers for the receive DMA completion block.
  Assumes a single 20 MHz clock and a 32-bit Avalon-MM register bus.
*/
package rx_dma_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_BYTE_COUNTS = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_COMP_PTR = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_FIRST_DESC = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h10;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int TOTAL_LSB = 16;
  localparam int PTR_LSB = 2;
  localparam int MODE_BIT = 0;
  localparam int IN_PACKET_BIT = 0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [29:0] PTR_RESET = 30'h00000000;
  localparam logic [31:0] DESC_WORD3_OFFSET = 32'h0000000C;

  // ----------------------------------------------------------------
  // event bits of the status and mask registers
  // ----------------------------------------------------------------
  localparam int NUM_EVENTS = 3;
  localparam int EV_COMPLETE = 0;
  localparam int EV_BUF_EMPTY = 1;
  localparam int EV_OVERRUN = 2;
  localparam logic [NUM_EVENTS-1:0] MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pkt_start;
    logic [29:0] start_ptr;
    logic buf_load;
    logic [15:0] buf_len;
    logic byte_strobe;
    logic pkt_end;
    logic [29:0] end_ptr;
  } rx_stream_s;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [15:0] count;
  } desc_write_s;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    return (old_v & ~be_mask(be)) | (new_v & be_mask(be));
  endfunction

endpackage

// ==== rx_engine_model.sv ====
/*
  Packet engine model: drives the receive stream and captures every
  descriptor write-back pulse.
  Assumes its tasks are entered just after a rising mclk edge.
*/
`timescale 1ns/1ns
module rx_engine_model (
  // clock
  input wire logic mclk,
  // stream out, write-back in
  output rx_dma_pkg::rx_stream_s rx_stream,
  input rx_dma_pkg::desc_write_s desc_write
);
  import rx_dma_pkg::*;

  int wb_count = 0;
  logic [31:0] wb_addr = 32'h00000000;
  logic [15:0] wb_total = 16'h0000;

  initial rx_stream = '0;

  // ----------------------------------------------------------------
  // one stream cycle; flags are {start, load, byte, end}
  // ----------------------------------------------------------------
  // unused data fields show the inverse of their last value, so the
  // design cannot lean on stale pointers or lengths
  task automatic drive(input logic [3:0] f, input logic [29:0] p,
                       input logic [15:0] l);
    rx_stream_s s;
    s = rx_stream;
    s.pkt_start = f[3];
    s.start_ptr = f[3] ? p : ~rx_stream.start_ptr;
    s.buf_load = f[2];
    s.buf_len = f[2] ? l : ~rx_stream.buf_len;
    s.byte_strobe = f[1];
    s.pkt_end = f[0];
    s.end_ptr = f[0] ? p : ~rx_stream.end_ptr;
    rx_stream <= s;
    @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // descriptor memory side: word 3 of the first descriptor
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (desc_write.valid === 1'b1) begin
      wb_count <= wb_count + 1;
      wb_addr <= desc_write.addr;
      wb_total <= desc_write.count;
    end
  end
endmodule

// ==== tb.sv ====
/*
  Self-checking bench for the receive DMA completion block.
  Assumes the packet engine model sits on the stream port.
*/
`timescale 1ns/1ns
module tb;
  import rx_dma_pkg::*;

  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  rx_stream_s rx_stream;
  desc_write_s desc_write;
  logic irq;
  int err_count = 0;
  int checked = 0;
  logic [31:0] rd;
  localparam logic [29:0] PA = 30'h00001000;
  localparam logic [29:0] PB = 30'h0ABCDEF0;
  localparam logic [29:0] PC = 30'h00002340;
  localparam logic [29:0] PD = 30'h01234560;

  always #25 mclk = ~mclk;

  rx_dma_completion_state u_rx_dma_completion_state (
    .mclk(mclk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_stream(rx_stream), .desc_write(desc_write), .irq(irq)
  );

  rx_engine_model u_rx_engine_model (
    .mclk(mclk), .rx_stream(rx_stream), .desc_write(desc_write)
  );

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // bus and wait helpers
  // ----------------------------------------------------------------
  // the request stands until waitrequest is seen low at a rising edge;
  // read data is taken at that same edge, then the request is dropped
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      $display("[ERR] %0t bus never answered", $time);
      final_report();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(rd, e);
  endtask

  task automatic irq_is(input logic e);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (irq !== e && n < 4);
    chk({31'h00000000, irq}, {31'h00000000, e});
    if (irq !== e) final_report();
    @(posedge mclk);
  endtask

  task automatic wb_wait(input int e);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (u_rx_engine_model.wb_count != e && n < 8);
    chk(32'(u_rx_engine_model.wb_count), 32'(e));
    if (u_rx_engine_model.wb_count != e) final_report();
    @(posedge mclk);
  endtask

  task automatic sd(input logic [3:0] f, input logic [29:0] p,
                    input logic [15:0] l);
    u_rx_engine_model.drive(f, p, l);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    rchk(OFS_BYTE_COUNTS, 32'h00000000);
    rchk(OFS_COMP_PTR, 32'h00000000);
    rchk(OFS_FIRST_DESC, 32'h00000000);
    rchk(OFS_IRQ_MASK, 32'h00000000);
    irq_is(1'b0);
    // short buffer: start, load and first byte land in one cycle
    sd(4'hE, PA, 16'h0004);
    sd(4'h0, 30'h00000000, 16'h0000);
    rchk(OFS_FIRST_DESC, {PA, 2'b01});
    rchk(OFS_BYTE_COUNTS, 32'h00010003);
    repeat (4) sd(4'h2, 30'h00000000, 16'h0000);
    sd(4'h1, PB, 16'h0000);
    sd(4'h0, 30'h00000000, 16'h0000);
    wb_wait(1);
    chk(u_rx_engine_model.wb_addr, {PA, 2'b00} + DESC_WORD3_OFFSET);
    chk({16'h0000, u_rx_engine_model.wb_total}, 32'h00000005);
    rchk(OFS_BYTE_COUNTS, 32'h00050000);
    rchk(OFS_FIRST_DESC, {PA, 2'b00});
    rchk(OFS_COMP_PTR, {PB, 2'b00});
    rchk(OFS_IRQ_STATUS, 32'h00000007);
    irq_is(1'b0);
    wr(OFS_IRQ_MASK, 32'h00000001);
    irq_is(1'b1);
    wr(OFS_IRQ_STATUS, 32'h00000006);
    rchk(OFS_IRQ_STATUS, 32'h00000001);
    // a stale pointer must not acknowledge
    wr(OFS_COMP_PTR, {PB ^ 30'h00000001, 2'b00});
    irq_is(1'b1);
    wr(OFS_COMP_PTR, {PB, 2'b00});
    irq_is(1'b0);
    rchk(OFS_COMP_PTR, {PB, 2'b00});
    wr(OFS_COMP_PTR, 32'hFFFFFFFF);
    rchk(OFS_COMP_PTR, 32'hFFFFFFFC);
    irq_is(1'b1);
    wr(OFS_COMP_PTR, 32'hFFFFFFFC);
    irq_is(1'b0);
    wr(OFS_BYTE_COUNTS, 32'h12345678);
    rchk(OFS_BYTE_COUNTS, 32'h12345678);
    wr(5'h14, 32'hFFFFFFFF);
    rchk(5'h14, 32'h00000000);
    // second packet: a byte arrives on the end cycle
    sd(4'hE, PC, 16'h0100);
    sd(4'h2, 30'h00000000, 16'h0000);
    sd(4'h3, PD, 16'h0000);
    sd(4'h0, 30'h00000000, 16'h0000);
    wb_wait(2);
    chk(u_rx_engine_model.wb_addr, {PC, 2'b00} + DESC_WORD3_OFFSET);
    chk({16'h0000, u_rx_engine_model.wb_total}, 32'h00000003);
    rchk(OFS_BYTE_COUNTS, 32'h000300FD);
    rchk(OFS_COMP_PTR, {PD, 2'b00});
    irq_is(1'b1);
    final_report();
  end
endmodule
